/* File: design/tap_defines.vh */
// Constants for the boundary-scan test access port
`ifndef TAP_DEFINES_VH
`define TAP_DEFINES_VH

// Instruction register
`define IR_WIDTH 8
`define IR_CAPTURE_VAL 8'h81
`define IR_BYPASS_CODE 8'hFF
`define IR_RESET_VAL 8'hFF

// Bypass register capture value
`define BYPASS_CAPTURE 1'b0

// Scan-history stream
`define HIST_WIDTH 8
`define HIST_RESET 8'h00
`define FIFO_DEPTH 32
`define FIFO_AW 5

// Test-clock timing, the bench runs the test clock at this period
`define SYS_CLK_NS 50
`define TCK_PERIOD_NS 400
`define TCK_CYCLES (`TCK_PERIOD_NS / `SYS_CLK_NS)

// TAP state codes
`define ST_TLR 4'h0
`define ST_RTI 4'h1
`define ST_SEL_DR 4'h2
`define ST_CAP_DR 4'h3
`define ST_SHF_DR 4'h4
`define ST_EX1_DR 4'h5
`define ST_PAU_DR 4'h6
`define ST_EX2_DR 4'h7
`define ST_UPD_DR 4'h8
`define ST_SEL_IR 4'h9
`define ST_CAP_IR 4'hA
`define ST_SHF_IR 4'hB
`define ST_EX1_IR 4'hC
`define ST_PAU_IR 4'hD
`define ST_EX2_IR 4'hE
`define ST_UPD_IR 4'hF

`endif

/* File: design/scan_fifo.v */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none

module scan_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 32,
	parameter AW = 5
) (
	input wire sys_clk,
	input wire reset,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);

	reg [WIDTH-1:0] mem_r [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_r;
	reg [AW-1:0] rd_ptr_r;
	reg [AW:0] count_r;
	wire push;
	wire pop;

	assign in_ready = (count_r != DEPTH[AW:0]);
	assign out_valid = (count_r != {(AW+1){1'b0}});
	assign out_data = mem_r[rd_ptr_r];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always @(posedge sys_clk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end

	always @(posedge sys_clk) begin
		if (reset) begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
			end
			if (push & ~pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop & ~push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end

endmodule // scan_fifo

`default_nettype wire

/* File: design/tap_port.v */
// Boundary-scan test access port: controller, instruction and bypass registers
//
// Notes on behaviour
// - Sample test inputs on test-clock rise
// - Change test output only on falling edge
// - Capture-IR loads fixed pattern 10000001
// - Shift-IR shifts instruction, last bit entering Exit1
// - Enable test output falling edge after Shift
// - Float test output falling edge after Exit1
// - Update-IR latches instruction on falling edge
// - All-ones instruction selects bypass register
// - Bypass captures zero leaving Capture-DR
// - Update-DR transfers shifted data on falling edge
// - Bypass acts as one-cycle delay
// - Unsupported instructions behave as bypass
`timescale 1ns/100ps
`default_nettype none
`include "tap_defines.vh"

module tap_port #(
	parameter IR_W = `IR_WIDTH,
	parameter HIST_W = `HIST_WIDTH,
	parameter DEPTH = `FIFO_DEPTH,
	parameter AW = `FIFO_AW
) (
	input wire sys_clk,
	input wire reset,
	input wire tck,
	input wire tms,
	input wire tdi,
	output wire tdo_o,
	output wire tdo_oe,
	output wire [IR_W-1:0] instr_active,
	output wire bypass_sel,
	output wire [3:0] tap_state,
	output wire scan_ready,
	output wire scan_valid,
	input wire scan_take,
	output wire [HIST_W-1:0] scan_data
);

	localparam [3:0] TLR = `ST_TLR;
	localparam [3:0] RTI = `ST_RTI;
	localparam [3:0] SEL_DR = `ST_SEL_DR;
	localparam [3:0] CAP_DR = `ST_CAP_DR;
	localparam [3:0] SHF_DR = `ST_SHF_DR;
	localparam [3:0] EX1_DR = `ST_EX1_DR;
	localparam [3:0] PAU_DR = `ST_PAU_DR;
	localparam [3:0] EX2_DR = `ST_EX2_DR;
	localparam [3:0] UPD_DR = `ST_UPD_DR;
	localparam [3:0] SEL_IR = `ST_SEL_IR;
	localparam [3:0] CAP_IR = `ST_CAP_IR;
	localparam [3:0] SHF_IR = `ST_SHF_IR;
	localparam [3:0] EX1_IR = `ST_EX1_IR;
	localparam [3:0] PAU_IR = `ST_PAU_IR;
	localparam [3:0] EX2_IR = `ST_EX2_IR;
	localparam [3:0] UPD_IR = `ST_UPD_IR;

	// Only the all-ones code is defined here; all others fall back to bypass
	function is_bypass;
		input [IR_W-1:0] code;
		begin
			case (code)
				`IR_BYPASS_CODE: is_bypass = 1'b1;
				default: is_bypass = 1'b1;
			endcase
		end
	endfunction

	// Next state of the controller for a given mode bit
	function [3:0] next_state;
		input [3:0] cur;
		input m;
		begin
			case (cur)
				TLR: next_state = m ? TLR : RTI;
				RTI: next_state = m ? SEL_DR : RTI;
				SEL_DR: next_state = m ? SEL_IR : CAP_DR;
				CAP_DR: next_state = m ? EX1_DR : SHF_DR;
				SHF_DR: next_state = m ? EX1_DR : SHF_DR;
				EX1_DR: next_state = m ? UPD_DR : PAU_DR;
				PAU_DR: next_state = m ? EX2_DR : PAU_DR;
				EX2_DR: next_state = m ? UPD_DR : SHF_DR;
				UPD_DR: next_state = m ? SEL_DR : RTI;
				SEL_IR: next_state = m ? TLR : CAP_IR;
				CAP_IR: next_state = m ? EX1_IR : SHF_IR;
				SHF_IR: next_state = m ? EX1_IR : SHF_IR;
				EX1_IR: next_state = m ? UPD_IR : PAU_IR;
				PAU_IR: next_state = m ? EX2_IR : PAU_IR;
				EX2_IR: next_state = m ? UPD_IR : SHF_IR;
				UPD_IR: next_state = m ? SEL_DR : RTI;
				default: next_state = TLR;
			endcase
		end
	endfunction

	// Pin synchronisers
	// TMS and TDI reset high, their idle level, so no false step follows reset
	reg tck_s1_r;
	reg tck_s2_r;
	reg tck_d_r;
	reg tms_s1_r;
	reg tms_s2_r;
	reg tdi_s1_r;
	reg tdi_s2_r;
	wire tck_rise;
	wire tck_fall;

	always @(posedge sys_clk) begin
		if (reset) begin
			tck_s1_r <= 1'b0;
			tck_s2_r <= 1'b0;
			tck_d_r <= 1'b0;
			tms_s1_r <= 1'b1;
			tms_s2_r <= 1'b1;
			tdi_s1_r <= 1'b1;
			tdi_s2_r <= 1'b1;
		end else begin
			tck_s1_r <= tck;
			tck_s2_r <= tck_s1_r;
			tck_d_r <= tck_s2_r;
			tms_s1_r <= tms;
			tms_s2_r <= tms_s1_r;
			tdi_s1_r <= tdi;
			tdi_s2_r <= tdi_s1_r;
		end
	end

	// Test-clock edges as one-cycle enables; all test logic steps on these except the Test-Logic-Reset restore of the instruction
	assign tck_rise = tck_s2_r & ~tck_d_r;
	assign tck_fall = ~tck_s2_r & tck_d_r;

	// Controller
	// Five TMS-high rises reach Test-Logic-Reset from any state
	reg [3:0] state_r;
	wire [3:0] state_nxt;

	assign state_nxt = next_state(state_r, tms_s2_r);

	always @(posedge sys_clk) begin
		if (reset) begin
			state_r <= TLR;
		end else if (tck_rise) begin
			state_r <= state_nxt;
		end
	end

	// State decodes shared by the registers below
	wire in_tlr;
	wire in_cap_ir;
	wire in_shf_ir;
	wire in_upd_ir;
	wire in_cap_dr;
	wire in_shf_dr;
	wire in_upd_dr;
	wire in_shift;

	assign in_tlr = (state_r == TLR);
	assign in_cap_ir = (state_r == CAP_IR);
	assign in_shf_ir = (state_r == SHF_IR);
	assign in_upd_ir = (state_r == UPD_IR);
	assign in_cap_dr = (state_r == CAP_DR);
	assign in_shf_dr = (state_r == SHF_DR);
	assign in_upd_dr = (state_r == UPD_DR);
	assign in_shift = in_shf_ir | in_shf_dr;

	// Instruction shift stage and active latch
	reg [IR_W-1:0] ir_shift_r;
	reg [IR_W-1:0] ir_active_r;

	always @(posedge sys_clk) begin
		if (reset) begin
			ir_shift_r <= `IR_CAPTURE_VAL;
		end else if (tck_rise) begin
			if (in_cap_ir) begin
				ir_shift_r <= `IR_CAPTURE_VAL;
			end else if (in_shf_ir) begin
				ir_shift_r <= {tdi_s2_r, ir_shift_r[IR_W-1:1]};
			end
		end
	end

	always @(posedge sys_clk) begin
		if (reset) begin
			ir_active_r <= `IR_RESET_VAL;
		end else if (in_tlr) begin
			// Test-Logic-Reset restores the bypass code
			ir_active_r <= `IR_RESET_VAL;
		end else if (tck_fall && in_upd_ir) begin
			ir_active_r <= ir_shift_r;
		end
	end

	wire byp_sel;

	assign byp_sel = is_bypass(ir_active_r);

	// Bypass register and scan history of the data path
	reg bypass_r;
	reg [HIST_W-1:0] hist_r;

	always @(posedge sys_clk) begin
		if (reset) begin
			bypass_r <= `BYPASS_CAPTURE;
			hist_r <= `HIST_RESET;
		end else if (tck_rise) begin
			if (in_cap_dr && byp_sel) begin
				bypass_r <= `BYPASS_CAPTURE;
			end else if (in_shf_dr && byp_sel) begin
				bypass_r <= tdi_s2_r;
			end
			if (in_shf_dr) begin
				hist_r <= {tdi_s2_r, hist_r[HIST_W-1:1]};
			end
		end
	end

	// Test data output, moved only on test-clock falling edges
	// Outside the shift states the output keeps its last value
	reg tdo_r;
	reg tdo_oe_r;
	reg tdo_nxt;

	always @* begin
		case (state_r)
			SHF_IR: tdo_nxt = ir_shift_r[0];
			SHF_DR: tdo_nxt = bypass_r;
			default: tdo_nxt = tdo_r;
		endcase
	end

	always @(posedge sys_clk) begin
		if (reset) begin
			tdo_r <= 1'b0;
			tdo_oe_r <= 1'b0;
		end else if (tck_fall) begin
			tdo_r <= tdo_nxt;
			tdo_oe_r <= in_shift;
		end
	end

	// Update stage: loaded on every Update-DR fall, even when the stream is stalled
	reg [HIST_W-1:0] dr_update_r;
	reg upd_strobe_r;

	always @(posedge sys_clk) begin
		if (reset) begin
			dr_update_r <= `HIST_RESET;
			upd_strobe_r <= 1'b0;
		end else begin
			upd_strobe_r <= tck_fall & in_upd_dr;
			if (tck_fall && in_upd_dr) begin
				dr_update_r <= hist_r;
			end
		end
	end

	// Stream push, one cycle after the update stage loads
	// A word arriving while one is pending and the buffer is full is lost
	reg push_r;
	reg [HIST_W-1:0] push_data_r;
	wire fifo_in_ready;

	always @(posedge sys_clk) begin
		if (reset) begin
			push_r <= 1'b0;
			push_data_r <= `HIST_RESET;
		end else if (upd_strobe_r && (!push_r || fifo_in_ready)) begin
			push_r <= 1'b1;
			push_data_r <= dr_update_r;
		end else if (fifo_in_ready) begin
			push_r <= 1'b0;
		end
	end

	scan_fifo #(
		.WIDTH(HIST_W),
		.DEPTH(DEPTH),
		.AW(AW)
	) u_fifo (
		.sys_clk(sys_clk),
		.reset(reset),
		.in_valid(push_r),
		.in_ready(fifo_in_ready),
		.in_data(push_data_r),
		.out_valid(scan_valid),
		.out_ready(scan_take),
		.out_data(scan_data)
	);

	assign tdo_o = tdo_r;
	assign tdo_oe = tdo_oe_r;
	assign instr_active = ir_active_r;
	assign bypass_sel = byp_sel;
	assign tap_state = state_r;
	assign scan_ready = fifo_in_ready & ~push_r;

endmodule // tap_port

`default_nettype wire

/* File: testbench/tap_port_checker.sv */
// Checker on the test access port outputs
`timescale 1ns/100ps
`default_nettype none
`include "tap_defines.vh"
module tap_port_checker #(parameter IR_W = 8, parameter HIST_W = 8) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic tdo_o,
	input wire logic tdo_oe,
	input wire logic [IR_W-1:0] instr_active,
	input wire logic bypass_sel,
	input wire logic [3:0] tap_state,
	input wire logic scan_ready,
	input wire logic scan_valid,
	input wire logic scan_take,
	input wire logic [HIST_W-1:0] scan_data
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	AST_STATE_ON_RISE: assert property ($changed(tap_state) |-> tck)
		else $error("state moved in low clock phase");
	AST_OE_ON_FALL: assert property ($changed(tdo_oe) |-> !tck)
		else $error("enable moved in high clock phase");
	AST_TDO_ON_FALL: assert property ($changed(tdo_o) |-> !tck)
		else $error("data out moved in high clock phase");
	AST_OE_RISE_SHIFT: assert property ($rose(tdo_oe) |->
		tap_state == `ST_SHF_IR || tap_state == `ST_SHF_DR)
		else $error("enable rose outside shift");
	AST_OE_FALL_EXIT: assert property ($fell(tdo_oe) |->
		tap_state == `ST_EX1_IR || tap_state == `ST_EX1_DR)
		else $error("enable fell outside exit1");
	AST_IR_UPDATE: assert property ($changed(instr_active) |-> !tck &&
		(tap_state == `ST_UPD_IR || tap_state == `ST_TLR))
		else $error("instruction changed outside update");
	AST_BYPASS_ALWAYS: assert property (bypass_sel == 1'b1)
		else $error("bypass not selected");
	AST_PUSH_UPD_DR: assert property ($rose(scan_valid) |-> tap_state == `ST_UPD_DR)
		else $error("word pushed outside update");
endmodule // tap_port_checker
bind tap_port tap_port_checker #(.IR_W(IR_W), .HIST_W(HIST_W)) tap_port_checker_inst (
	.sys_clk(sys_clk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o),
	.tdo_oe(tdo_oe), .instr_active(instr_active), .bypass_sel(bypass_sel),
	.tap_state(tap_state), .scan_ready(scan_ready), .scan_valid(scan_valid),
	.scan_take(scan_take), .scan_data(scan_data));
`default_nettype wire

/* File: testbench/tap_ctrl_model.sv */
// Behavioural test controller for the link pins
`timescale 1ns/100ps
`default_nettype none
module tap_ctrl_model (
	input wire logic sys_clk,
	input wire logic tdo_o,
	input wire logic tdo_oe,
	output logic tck,
	output logic tms,
	output logic tdi
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// One test-clock cycle, 400 ns; clock idles low between calls
	task step(input logic m, input logic d, output logic q, output logic oe);
		@(posedge sys_clk);
		tms <= m;
		tdi <= d;
		repeat (3) @(posedge sys_clk);
		q = tdo_o;
		oe = tdo_oe;
		tck <= 1'b1;
		repeat (4) @(posedge sys_clk);
		tck <= 1'b0;
	endtask
endmodule // tap_ctrl_model
`default_nettype wire

/* File: testbench/tap_port_tb_top.sv */
// Testbench for the test access port
`timescale 1ns/100ps
`default_nettype none
`include "tap_defines.vh"
module tap_port_tb_top;
	logic sys_clk, reset, scan_take, q, oe;
	wire tck, tms, tdi, tdo_o, tdo_oe, bypass_sel, scan_ready, scan_valid;
	wire [7:0] instr_active, scan_data;
	wire [3:0] tap_state;
	int bad_count, checked, cyc;
	logic [7:0] got;
	// Instruction, scanned data, expected pushed word
	logic [23:0] rows [4] = '{24'hFFA5A5, 24'h003C3C, 24'h5A0101, 24'h81FEFE};
	tap_port tap_port_inst (.sys_clk(sys_clk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo_o(tdo_o), .tdo_oe(tdo_oe), .instr_active(instr_active), .bypass_sel(bypass_sel),
		.tap_state(tap_state), .scan_ready(scan_ready), .scan_valid(scan_valid),
		.scan_take(scan_take), .scan_data(scan_data));
	tap_ctrl_model tap_ctrl_model_inst (.sys_clk(sys_clk), .tdo_o(tdo_o), .tdo_oe(tdo_oe),
		.tck(tck), .tms(tms), .tdi(tdi));
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	task tally_and_finish;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 10000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task st(input logic m, input logic d);
		tap_ctrl_model_inst.step(m, d, q, oe);
	endtask
	// Shift n bits, mode high on the last, then enter Update
	task scan(input int n, input logic [7:0] v, input logic [7:0] e);
		for (int i = 0; i < n; i++) begin
			st(i == n - 1, v[i]);
			chk("tdo_o", {7'h00, e[i]}, {7'h00, q});
			chk("tdo_oe", 8'h01, {7'h00, oe});
		end
		st(1'b1, 1'b0);
		chk("tdo_oe exit", 8'h00, {7'h00, oe});
	endtask
	initial begin
		reset = 1'b1;
		scan_take = 1'b0;
		bad_count = 0;
		checked = 0;
		cyc = 0;
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		st(1'b0, 1'b0);
		st(1'b1, 1'b0);
		for (int r = 0; r < 4; r++) begin
			st(1'b1, 1'b0);
			st(1'b0, 1'b0);
			st(1'b0, 1'b0);
			scan(8, rows[r][23:16], 8'h81);
			st(1'b1, 1'b0);
			chk("instr_active", rows[r][23:16], instr_active);
			chk("bypass_sel", 8'h01, {7'h00, bypass_sel});
			st(1'b0, 1'b0);
			st(1'b0, 1'b0);
			scan(8, rows[r][15:8], {rows[r][14:8], 1'b0});
			st(1'b1, 1'b0);
			chk("scan_data", rows[r][7:0], scan_data);
			chk("scan_valid", 8'h01, {7'h00, scan_valid});
			scan_take <= 1'b1;
			@(posedge sys_clk);
			scan_take <= 1'b0;
		end
		$display("test rows done");
		// Fill past depth with consumer stalled; one pending, one dropped
		for (int i = 0; i < 34; i++) begin
			st(1'b0, 1'b0);
			st(1'b0, 1'b0);
			st(1'b1, i[0]);
			st(1'b1, 1'b0);
			st(1'b1, 1'b0);
		end
		chk("scan_ready full", 8'h00, {7'h00, scan_ready});
		got = 8'h00;
		scan_take <= 1'b1;
		repeat (40) @(negedge sys_clk) if (scan_valid === 1'b1) got++;
		@(posedge sys_clk);
		scan_take <= 1'b0;
		chk("words drained", 8'h21, got);
		chk("scan_valid empty", 8'h00, {7'h00, scan_valid});
		$display("test fill done");
		st(1'b0, 1'b0);
		st(1'b0, 1'b0);
		st(1'b0, 1'b1);
		repeat (5) st(1'b1, 1'b0);
		chk("tap_state five high", {4'h0, `ST_TLR}, {4'h0, tap_state});
		$display("test five high done");
		// Load a non-reset instruction, then reset in mid-shift
		st(1'b0, 1'b0);
		st(1'b1, 1'b0);
		st(1'b1, 1'b0);
		st(1'b0, 1'b0);
		st(1'b0, 1'b0);
		scan(8, 8'h3C, 8'h81);
		st(1'b1, 1'b0);
		chk("instr_active loaded", 8'h3C, instr_active);
		st(1'b0, 1'b0);
		st(1'b0, 1'b0);
		st(1'b0, 1'b1);
		chk("tdo_oe before reset", 8'h01, {7'h00, oe});
		reset <= 1'b1;
		repeat (4) @(posedge sys_clk);
		reset <= 1'b0;
		chk("tap_state reset", 8'h00, {4'h0, tap_state});
		chk("tdo_oe reset", 8'h00, {7'h00, tdo_oe});
		chk("instr_active reset", 8'hFF, instr_active);
		chk("scan_valid reset", 8'h00, {7'h00, scan_valid});
		chk("scan_ready reset", 8'h01, {7'h00, scan_ready});
		st(1'b0, 1'b0);
		st(1'b1, 1'b0);
		st(1'b1, 1'b0);
		st(1'b0, 1'b0);
		st(1'b0, 1'b0);
		scan(8, 8'hC3, 8'h81);
		st(1'b1, 1'b0);
		chk("instr_active after reset", 8'hC3, instr_active);
		$display("test reset done");
		tally_and_finish();
	end
endmodule // tap_port_tb_top
`default_nettype wire
